// file: design/smc_pkg.sv
// Shared constants for the serial peripheral master core.
package smc_pkg;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int SMC_CLK_MHZ = 100;
    localparam int SMC_SCLK_MAX_MHZ = 52;
    // Smallest half period in core cycles that keeps the serial clock at or below its ceiling.
    localparam int SMC_MIN_HALF = (SMC_CLK_MHZ + 2 * SMC_SCLK_MAX_MHZ - 1) / (2 * SMC_SCLK_MAX_MHZ);
    localparam logic [7:0] SMC_MIN_HALF_W = 8'(SMC_MIN_HALF);
    // ----------------------------------------------------------------
    // Word length limits and field widths
    // ----------------------------------------------------------------
    localparam logic [5:0] SMC_LEN_MIN = 6'h04;
    localparam logic [5:0] SMC_LEN_MAX = 6'h20;
    localparam int SMC_NSEL = 4;
    // ----------------------------------------------------------------
    // Duplex modes
    // ----------------------------------------------------------------
    localparam logic [1:0] SMC_DUP_FULL = 2'h0;
    localparam logic [1:0] SMC_DUP_TX = 2'h1;
    localparam logic [1:0] SMC_DUP_RX = 2'h2;
    localparam logic [1:0] SMC_DUP_BIDIR = 2'h3;
    localparam logic [2:0] SMC_CFG_THREE = 3'h3;
    typedef enum logic [2:0] {
        SMC_IDLE = 3'b000,
        SMC_DEAD = 3'b001,
        SMC_LEAD = 3'b010,
        SMC_TRAIL = 3'b011,
        SMC_GAP = 3'b100
    } smc_state_e;
endpackage : smc_pkg

// file: design/smc_master.sv
// Serial peripheral master: word engine, selects, clock and data pins.
// Contract
// - Works in bus configurations one to five as the only master; clock and selects are always driven.
// - Four separate slave select outputs, each low when asserted by default.
// - Idle serial clock rests at the level given by the polarity input.
// - Optional free running serial clock in idle; dead time holds it at rest.
// - Optional high impedance on master out during idle.
// - Input first mode samples on leading edge, output changes on trailing.
// - Output first mode launches on leading edge, samples on trailing.
// - Word length programmable from 4 to 32 bits.
// - Transmit only holds master in low; receive only holds master out low.
// - Shared bidirectional data line only allowed in configuration three.
// - Programmable serial clock ticks of dead time before a select asserts.
// - By default the select is asserted per word and released between words.
// - Multiword mode holds select over a word count, clock stops between words.
// - Each select may be set active high instead of active low.
// - Serial clock never exceeds 52 MHz whatever divider is chosen.
`timescale 1ns/1ps
`default_nettype none
module smc_master
    import smc_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Configuration
    input wire logic clk_idle_high_i,
    input wire logic clk_free_run_i,
    input wire logic mosi_idle_tristate_i,
    input wire logic input_first_i,
    input wire logic [5:0] word_len_i,
    input wire logic [1:0] duplex_mode_i,
    input wire logic [2:0] sys_config_i,
    input wire logic [7:0] half_period_i,
    input wire logic [7:0] dead_ticks_i,
    input wire logic held_select_multiword_i,
    input wire logic [7:0] word_count_i,
    input wire logic [3:0] select_active_high_i,
    input wire logic [1:0] select_index_i,
    // Word interface
    input wire logic start_i,
    input wire logic [31:0] tx_data_i,
    output logic busy_o,
    output logic word_done_o,
    output logic [31:0] rx_data_o,
    output logic config_error_o,
    // Serial pins
    output logic sclk_o,
    output logic mosi_o,
    output logic mosi_oe_n_o,
    input wire logic miso_i,
    output logic slave_select_zero_low_o,
    output logic slave_select_one_low_o,
    output logic slave_select_two_low_o,
    output logic slave_select_three_low_o
);
    function automatic logic [7:0] smc_half(input logic [7:0] req);
        smc_half = (req < SMC_MIN_HALF_W) ? SMC_MIN_HALF_W : req;
    endfunction : smc_half

    // ----------------------------------------------------------------
    // Pin input synchroniser
    // ----------------------------------------------------------------
    logic [2:0] miso_sync_reg;
    logic miso_reg;
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            miso_sync_reg <= 3'h0;
            miso_reg <= 1'b0;
        end else begin
            miso_sync_reg <= {miso_sync_reg[1:0], miso_i};
            if (miso_sync_reg[1] == miso_sync_reg[2]) begin
                miso_reg <= miso_sync_reg[2];
            end
        end
    end
    // A change counts as soon as the second and third stages agree.
    // Waiting for the held copy would cost a cycle and miss the bit at a half period of four.
    wire logic miso_agree = (miso_sync_reg[1] == miso_sync_reg[2]);
    wire logic miso_now = miso_agree ? miso_sync_reg[2] : miso_reg;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    wire logic [7:0] half_w = smc_half(half_period_i);
    wire logic len_ok = (word_len_i >= SMC_LEN_MIN) && (word_len_i <= SMC_LEN_MAX);
    wire logic bidir_bad = (duplex_mode_i == SMC_DUP_BIDIR) && (sys_config_i != SMC_CFG_THREE);
    wire logic cfg_bad = !len_ok || bidir_bad || (sys_config_i == 3'h0) || (sys_config_i > 3'h5);
    wire logic rx_in = (duplex_mode_i == SMC_DUP_TX) ? 1'b0 : miso_now;

    smc_state_e state_reg, state_next;
    logic [7:0] div_reg, div_next;
    logic [7:0] dead_reg, dead_next;
    logic [5:0] bit_reg, bit_next;
    logic [7:0] words_reg, words_next;
    logic [31:0] sh_reg, sh_next;
    logic [31:0] rx_reg, rx_next;
    logic [31:0] rxd_reg, rxd_next;
    logic sclk_reg, sclk_next;
    logic sel_reg, sel_next;
    logic [1:0] idx_reg, idx_next;
    logic [1:0] last_idx_reg, last_idx_next;
    logic done_reg, done_next;
    logic err_reg, err_next;
    logic mosi_reg, mosi_next;

    wire logic tick = (div_reg == 8'h00);
    wire logic [7:0] div_load = half_w - 8'h01;
    wire logic [5:0] len_m1 = word_len_i - 6'h01;
    wire logic active = (state_reg == SMC_LEAD) || (state_reg == SMC_TRAIL);
    wire logic last_bit = (bit_reg == 6'h00);
    wire logic more_words = held_select_multiword_i && (words_reg != 8'h00);
    wire logic tx_bit = (duplex_mode_i == SMC_DUP_RX) ? 1'b0 : sh_reg[len_m1[4:0]];

    // ----------------------------------------------------------------
    // Word sequencer
    // ----------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        div_next = tick ? div_load : div_reg - 8'h01;
        dead_next = dead_reg;
        bit_next = bit_reg;
        words_next = words_reg;
        sh_next = sh_reg;
        rx_next = rx_reg;
        rxd_next = rxd_reg;
        sclk_next = sclk_reg;
        sel_next = sel_reg;
        idx_next = idx_reg;
        last_idx_next = last_idx_reg;
        done_next = 1'b0;
        err_next = err_reg;
        mosi_next = mosi_reg;
        case (state_reg)
            SMC_IDLE: begin
                if (clk_free_run_i) begin
                    if (tick) begin
                        sclk_next = !sclk_reg;
                    end
                end else begin
                    sclk_next = clk_idle_high_i;
                end
                mosi_next = 1'b0;
                if (start_i) begin
                    err_next = cfg_bad;
                    if (!cfg_bad) begin
                        sh_next = tx_data_i;
                        idx_next = select_index_i;
                        words_next = held_select_multiword_i ? word_count_i - 8'h01 : 8'h00;
                        dead_next = dead_ticks_i;
                        div_next = div_load;
                        sclk_next = clk_idle_high_i;
                        state_next = SMC_DEAD;
                    end
                end
            end
            SMC_DEAD: begin
                sclk_next = clk_idle_high_i;
                if (tick) begin
                    if (dead_reg == 8'h00) begin
                        sel_next = 1'b1;
                        last_idx_next = idx_reg;
                        bit_next = len_m1;
                        rx_next = 32'h0;
                        if (!input_first_i) begin
                            mosi_next = tx_bit;
                        end
                        state_next = SMC_LEAD;
                    end else begin
                        dead_next = dead_reg - 8'h01;
                    end
                end
            end
            SMC_LEAD: begin
                if (tick) begin
                    sclk_next = !clk_idle_high_i;
                    if (input_first_i) begin
                        rx_next = {rx_reg[30:0], rx_in};
                    end else begin
                        mosi_next = tx_bit;
                    end
                    state_next = SMC_TRAIL;
                end
            end
            SMC_TRAIL: begin
                if (tick) begin
                    sclk_next = clk_idle_high_i;
                    if (!input_first_i) begin
                        rx_next = {rx_reg[30:0], rx_in};
                    end
                    sh_next = {sh_reg[30:0], 1'b0};
                    if (last_bit) begin
                        rxd_next = input_first_i ? rx_reg : {rx_reg[30:0], rx_in};
                        done_next = 1'b1;
                        state_next = SMC_GAP;
                    end else begin
                        bit_next = bit_reg - 6'h01;
                        if (input_first_i) begin
                            mosi_next = (duplex_mode_i == SMC_DUP_RX) ? 1'b0 : sh_reg[len_m1[4:0] - 5'h01];
                        end
                        state_next = SMC_LEAD;
                    end
                end
            end
            SMC_GAP: begin
                sclk_next = clk_idle_high_i;
                if (more_words) begin
                    if (start_i) begin
                        sh_next = tx_data_i;
                        words_next = words_reg - 8'h01;
                        dead_next = dead_ticks_i;
                        state_next = SMC_DEAD;
                    end
                end else begin
                    sel_next = 1'b0;
                    state_next = SMC_IDLE;
                end
            end
            default: begin
                state_next = SMC_IDLE;
            end
        endcase
        if (state_reg == SMC_DEAD && tick && dead_reg == 8'h00 && input_first_i) begin
            mosi_next = tx_bit;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_reg <= SMC_IDLE;
            div_reg <= 8'h00;
            dead_reg <= 8'h00;
            bit_reg <= 6'h00;
            words_reg <= 8'h00;
            sh_reg <= 32'h0;
            rx_reg <= 32'h0;
            rxd_reg <= 32'h0;
            sclk_reg <= 1'b0;
            sel_reg <= 1'b0;
            idx_reg <= 2'h0;
            last_idx_reg <= 2'h0;
            done_reg <= 1'b0;
            err_reg <= 1'b0;
            mosi_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            div_reg <= div_next;
            dead_reg <= dead_next;
            bit_reg <= bit_next;
            words_reg <= words_next;
            sh_reg <= sh_next;
            rx_reg <= rx_next;
            rxd_reg <= rxd_next;
            sclk_reg <= sclk_next;
            sel_reg <= sel_next;
            idx_reg <= idx_next;
            last_idx_reg <= last_idx_next;
            done_reg <= done_next;
            err_reg <= err_next;
            mosi_reg <= mosi_next;
        end
    end

    // ----------------------------------------------------------------
    // Pin drive
    // ----------------------------------------------------------------
    // Selects decode from the latched index so a host change mid word cannot glitch a line.
    logic [3:0] sel_onehot;
    assign sel_onehot = sel_reg ? (4'h1 << idx_reg) : 4'h0;
    wire logic [3:0] sel_pins = ~(sel_onehot ^ select_active_high_i);
    assign slave_select_zero_low_o = sel_pins[0];
    assign slave_select_one_low_o = sel_pins[1];
    assign slave_select_two_low_o = sel_pins[2];
    assign slave_select_three_low_o = sel_pins[3];
    assign sclk_o = sclk_reg;
    assign mosi_o = mosi_reg;
    // Only an idle bus with tri-state on releases the line; the shared line has no turnaround and is driven while selected.
    wire logic idle_bus = !sel_reg;
    assign mosi_oe_n_o = (idle_bus && mosi_idle_tristate_i) ? 1'b1 : 1'b0;
    assign busy_o = (state_reg != SMC_IDLE);
    assign word_done_o = done_reg;
    assign rx_data_o = rxd_reg;
    assign config_error_o = err_reg;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    // Cycles since the serial clock last moved, so the rate check measures real half periods.
    logic [7:0] sclk_age_reg;
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sclk_age_reg <= 8'h00;
        end else if (sclk_next != sclk_reg) begin
            sclk_age_reg <= 8'h00;
        end else if (sclk_age_reg != 8'hff) begin
            sclk_age_reg <= sclk_age_reg + 8'h01;
        end
    end
    sequence smc_trail_s;
        (state_reg == SMC_TRAIL) && tick;
    endsequence
    clk_idle_level_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (state_reg == SMC_IDLE && !clk_free_run_i) |=> (sclk_reg == $past(clk_idle_high_i)))
        else $error("Idle serial clock level wrong.");
    sclk_rate_a: assert property (@(posedge clk_i) disable iff (reset_i)
        smc_trail_s |-> (sclk_age_reg == div_load) && (half_w >= SMC_MIN_HALF_W))
        else $error("Serial clock half period wrong.");
    len_range_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (start_i && state_reg == SMC_IDLE && !len_ok) |=> (state_reg == SMC_IDLE && err_reg))
        else $error("Bad word length accepted.");
    bidir_cfg_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (start_i && state_reg == SMC_IDLE && bidir_bad) |=> (state_reg == SMC_IDLE))
        else $error("Shared line outside configuration three.");
    mosi_idle_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (state_reg == SMC_IDLE && $past(state_reg) == SMC_IDLE) |-> !mosi_reg)
        else $error("Master out not low in idle.");
    tristate_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (!sel_reg && mosi_idle_tristate_i) |-> mosi_oe_n_o)
        else $error("Master out driven in idle.");
    sel_release_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (state_reg == SMC_GAP && !more_words) |=> (!sel_reg && state_reg == SMC_IDLE))
        else $error("Select held after single word.");
    multi_hold_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (state_reg == SMC_GAP && more_words) |=> sel_reg && sclk_reg == clk_idle_high_i)
        else $error("Select dropped in multiword run.");
    rx_only_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (smc_trail_s and (duplex_mode_i == SMC_DUP_RX) and !last_bit and input_first_i) |=> !mosi_reg)
        else $error("Master out not low in receive only.");
    dead_time_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (state_reg == SMC_DEAD && dead_reg != 8'h00 && !sel_reg) |=> !sel_reg)
        else $error("Select asserted during dead time.");
endmodule : smc_master
`default_nettype wire

// file: bench/smc_slave_model.sv
// Behavioural serial slave that answers the master core from the far side of its pins.
`timescale 1ns/1ps
`default_nettype none
module smc_slave_model (
    // Settings mirrored from the master
    input wire logic cpol_i,
    input wire logic input_first_i,
    input wire logic hold_low_i,
    input wire logic [5:0] len_i,
    input wire logic [31:0] reply_i,
    // Serial pins
    input wire logic sel_i,
    input wire logic sclk_i,
    input wire logic mosi_i,
    output logic miso_o,
    output logic [31:0] got_o
);
    logic [31:0] shift_reg = 32'h0;
    logic lead;
    initial miso_o = 1'b0;
    initial got_o = 32'h0;
    // ----------------------------------------------------------------
    // Framing and bit timing
    // ----------------------------------------------------------------
    always @(posedge sel_i) begin
        shift_reg = reply_i << (6'h20 - len_i);
        got_o = 32'h0;
        miso_o = (hold_low_i | ~input_first_i) ? 1'b0 : shift_reg[31];
    end
    // A released line has no keeper, so it flips and a stale sample cannot pass by luck.
    always @(negedge sel_i) miso_o = ~miso_o;
    always @(sclk_i) begin
        if (sel_i) begin
            lead = (sclk_i !== cpol_i);
            if (lead == input_first_i) begin
                got_o = {got_o[30:0], mosi_i};
            end else begin
                if (input_first_i) shift_reg = shift_reg << 1;
                miso_o = hold_low_i ? 1'b0 : shift_reg[31];
                if (!input_first_i) shift_reg = shift_reg << 1;
            end
        end
    end
endmodule : smc_slave_model
`default_nettype wire

// file: bench/spi_master_core_bench.sv
// Self-checking bench for the serial peripheral master core.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; \
    $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module spi_master_core_bench;
    import smc_pkg::*;
    typedef struct {
        logic cpol, inf;
        logic [5:0] len;
        logic [1:0] dup;
        logic [7:0] half;
        logic [1:0] idx;
        logic [31:0] tx, reply, exp_rx, exp_got;
    } smc_row_s;
    smc_row_s rows[7];
    smc_row_s cur;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic free_run = 1'b0, tristate = 1'b0, multi = 1'b0, start = 1'b0;
    logic [2:0] cfg = 3'h1;
    logic [7:0] dead = 8'h00, words = 8'h02;
    logic [3:0] act_high = 4'h0;
    logic [31:0] mask;
    wire logic busy, done, cfg_err, sclk, mosi, oe_n, miso;
    wire logic [31:0] rx, got;
    wire logic [3:0] ss;
    wire logic sel = ss[cur.idx] ^ ~act_high[cur.idx];
    int fail_count = 0;
    int n_checks = 0;
    int cyc = 0;
    int n0, n1;
    // ----------------------------------------------------------------
    // Design and partner
    // ----------------------------------------------------------------
    smc_master u_smc_master (.clk_i(clk_i), .reset_i(reset_i), .clk_idle_high_i(cur.cpol),
        .clk_free_run_i(free_run), .mosi_idle_tristate_i(tristate), .input_first_i(cur.inf),
        .word_len_i(cur.len), .duplex_mode_i(cur.dup), .sys_config_i(cfg), .half_period_i(cur.half),
        .dead_ticks_i(dead), .held_select_multiword_i(multi), .word_count_i(words),
        .select_active_high_i(act_high), .select_index_i(cur.idx), .start_i(start), .tx_data_i(cur.tx),
        .busy_o(busy), .word_done_o(done), .rx_data_o(rx), .config_error_o(cfg_err), .sclk_o(sclk),
        .mosi_o(mosi), .mosi_oe_n_o(oe_n), .miso_i(miso), .slave_select_zero_low_o(ss[0]),
        .slave_select_one_low_o(ss[1]), .slave_select_two_low_o(ss[2]), .slave_select_three_low_o(ss[3]));
    smc_slave_model u_smc_slave_model (.cpol_i(cur.cpol), .input_first_i(cur.inf),
        .hold_low_i(cur.dup == SMC_DUP_TX), .len_i(cur.len), .reply_i(cur.reply), .sel_i(sel),
        .sclk_i(sclk), .mosi_i(mosi), .miso_o(miso), .got_o(got));
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            final_report();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : tick
    task automatic run_word(output int n);
        start = 1'b1;
        tick(1);
        start = 1'b0;
        n = 0;
        for (int k = 0; k < 4000 && done !== 1'b1; k++) begin
            if (sel !== 1'b1) n++;
            tick(1);
        end
        `CHK(done, 1'b1)
    endtask : run_word
    task automatic refuse(input logic [5:0] l, input logic [1:0] d);
        cur.len = l;
        cur.dup = d;
        start = 1'b1;
        tick(1);
        start = 1'b0;
        tick(1);
        `CHK({cfg_err, busy}, 2'b10)
    endtask : refuse
    task automatic final_report();
        $display("checks=%0d mismatches=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : final_report
    // ----------------------------------------------------------------
    // Stimulus
    // ----------------------------------------------------------------
    initial begin
        rows[0] = '{1'b0, 1'b0, 6'h08, 2'h0, 8'h04, 2'h0, 32'ha5, 32'h3c, 32'h3c, 32'ha5};
        rows[1] = '{1'b1, 1'b1, 6'h04, 2'h0, 8'h04, 2'h1, 32'hfffffff9, 32'h6, 32'h6, 32'h9};
        rows[2] = '{1'b0, 1'b1, 6'h20, 2'h0, 8'h04, 2'h2, 32'hdeadbeef, 32'h12345678, 32'h12345678, 32'hdeadbeef};
        rows[3] = '{1'b1, 1'b0, 6'h0d, 2'h0, 8'h04, 2'h3, 32'h1abc, 32'h0f0f, 32'h0f0f, 32'h1abc};
        rows[4] = '{1'b0, 1'b0, 6'h10, 2'h1, 8'h04, 2'h3, 32'hc3a1, 32'hffff, 32'h0, 32'hc3a1};
        rows[5] = '{1'b1, 1'b1, 6'h0c, 2'h2, 8'h04, 2'h0, 32'hfff, 32'h5a3, 32'h5a3, 32'h0};
        rows[6] = '{1'b0, 1'b0, 6'h08, 2'h1, 8'h00, 2'h1, 32'h81, 32'h0, 32'h0, 32'h81};
        cur = rows[0];
        tick(4);
        reset_i = 1'b0;
        tick(1);
        `CHK({busy, ss}, 5'h0f)
        foreach (rows[i]) begin
            cur = rows[i];
            cfg = 3'(i % 5 + 1);
            tick(2);
            run_word(n0);
            tick(2);
            mask = (cur.len == SMC_LEN_MAX) ? 32'hffffffff : ((32'h1 << cur.len) - 32'h1);
            `CHK(rx & mask, cur.exp_rx)
            `CHK(got, cur.exp_got)
            `CHK({sel, sclk}, {1'b0, cur.cpol})
            $display("row %0d finished", i);
        end
        `CHK({oe_n, mosi}, 2'b00)
        tristate = 1'b1;
        tick(2);
        `CHK(oe_n, 1'b1)
        tristate = 1'b0;
        free_run = 1'b1;
        n1 = 0;
        for (int k = 0; k < 40; k++) begin
            tick(1);
            if (sclk !== cur.cpol) n1++;
        end
        `CHK(n1 > 0 && ss === 4'hf, 1'b1)
        free_run = 1'b0;
        tick(4);
        `CHK(sclk, cur.cpol)
        $display("idle test finished");
        refuse(6'h03, SMC_DUP_FULL);
        refuse(6'h21, SMC_DUP_FULL);
        refuse(SMC_LEN_MIN, SMC_DUP_BIDIR);
        cfg = SMC_CFG_THREE;
        run_word(n0);
        tick(2);
        `CHK(cfg_err, 1'b0)
        $display("config test finished");
        cur = rows[0];
        run_word(n0);
        tick(2);
        dead = 8'h03;
        run_word(n1);
        tick(2);
        `CHK(n1 - n0, 4 * 3)
        $display("dead time test finished");
        multi = 1'b1;
        run_word(n0);
        tick(3);
        `CHK({sel, sclk}, {1'b1, cur.cpol})
        run_word(n0);
        tick(3);
        `CHK(sel, 1'b0)
        multi = 1'b0;
        $display("multiword test finished");
        act_high = 4'h4;
        cur.idx = 2'h2;
        tick(2);
        `CHK(ss[2], 1'b0)
        run_word(n0);
        tick(2);
        `CHK(got, cur.exp_got)
        act_high = 4'h0;
        start = 1'b1;
        tick(1);
        start = 1'b0;
        tick(30);
        reset_i = 1'b1;
        tick(1);
        reset_i = 1'b0;
        tick(1);
        `CHK({busy, ss}, 5'h0f)
        $display("select and reset test finished");
        final_report();
    end
endmodule : spi_master_core_bench
`default_nettype wire
